// *** pkg/dpll_pkg.sv ***
// Constants, carriers and state types for the digital loop core.
// Assumes one system clock of 50 MHz and an active-low asynchronous reset.
// Behaviour
// - Output clock tracks phase and frequency of the selected reference A or B.
// - Manual or automatic switchover to the other reference when active one is lost.
// - In holdover the synthesizer keeps running while the system clock runs.
// - Holdover frequency is an average of the steady-state tuning before holdover.
// - Selected reference divided by its modulus feeds the phase/frequency detector.
// - Reference divider: 16-bit counter plus optional divide-by-two.
// - Reference divider counts rising edges, or falling edges when selected.
// - Feedback divider: 16-bit counter plus optional divide-by-two.
// - Feedback divider counts rising edges, or falling edges when selected.
// - Oscillator runs at feedback modulus times detector input frequency.
// - Estimator measures detector input and presets tuning before tracking.
// - After the estimate, phase tracking starts and holds lock.
// - Coarse and fine detectors measure three-state detector pulse widths in parallel.
// - Detector outputs a word for the edge separation of reference and feedback.
// - Fine result used when valid; coarse used when the fine counter has saturated.
// - Each loop filter word drives the synthesizer tuning input.
// - Phase accumulator adds tuning word each cycle, wraps modulo 2^48.
// - Loop-closure input selects open-loop or closed-loop synthesis.
// - Holdover tuning comes from words recorded while the loop was closed.

package dpll_pkg;

	// ************************************************************
	// Widths and timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 20;
	localparam int FTW_W         = 48;
	localparam int DIV_W         = 16;
	localparam int PE_W          = 24;
	localparam int FINE_W        = 10;
	localparam int LOSS_W        = 24;
	localparam int SH_W          = 4;
	localparam int AVG_SHIFT     = 8;
	localparam int BIT_W         = 6;
	localparam int SYNC_N        = 3;
	localparam int NPIN          = 3;
	localparam int PIN_REF_A     = 0;
	localparam int PIN_REF_B     = 1;
	localparam int PIN_FB        = 2;
	localparam int REF_LOSS_NS   = 200000;
	localparam int LOSS_CYCLES   = (REF_LOSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ************************************************************
	// Reset, limit and divider step-count values
	// ************************************************************
	localparam logic [FTW_W-1:0] FTW_RESET = 48'h0;
	localparam logic [FTW_W-1:0] FTW_MAX   = 48'hFFFFFFFFFFFF;
	localparam logic [BIT_W-1:0] DIV_STEPS = 6'h2F;

	// ************************************************************
	// Types
	// ************************************************************
	typedef struct packed {
		logic [DIV_W-1:0] modulus;
		logic             div2;
		logic             fall;
	} div_cfg_t;

	typedef enum logic [2:0] {
		ST_OPEN   = 3'h0,
		ST_MEAS   = 3'h1,
		ST_DIVIDE = 3'h3,
		ST_TRACK  = 3'h2,
		ST_HOLD   = 3'h6
	} loop_state_t;

	typedef struct packed {
		logic [DIV_W-1:0] cnt;
		logic             half;
		logic             prev;
		logic             ev;
	} div_state_t;

	typedef struct packed {
		logic [NPIN-1:0][SYNC_N-1:0] sync;
		logic [NPIN-1:0]             lvl;
		logic [1:0][LOSS_W-1:0]      loss_cnt;
		logic [1:0]                  lost;
		logic                        active;
		logic                        up;
		logic                        dn;
		logic [PE_W-1:0]             coarse;
		logic [FINE_W-1:0]           fine;
		logic [PE_W-1:0]             err;
		logic                        err_vld;
		logic                        fine_sel;
		loop_state_t                 st;
		logic                        started;
		logic [PE_W-1:0]             per_cnt;
		logic [PE_W-1:0]             period;
		logic [PE_W:0]               rem;
		logic [FTW_W-1:0]            quo;
		logic [BIT_W-1:0]            bits;
		logic [FTW_W-1:0]            integ;
		logic [FTW_W-1:0]            frequency_tuning_word;
		logic [FTW_W-1:0]            avg;
		logic                        hist;
		logic [FTW_W-1:0]            acc;
	} core_state_t;

endpackage : dpll_pkg

// *** rtl/dpll_divider.sv ***
// Programmable edge divider: 16-bit modulus counter with optional divide-by-two.
// Assumes its level input is already synchronised to the system clock.
`timescale 1ns/10ps
`default_nettype none

module dpll_divider (
	// Clock and reset
	input  wire logic               i_sys_clk,
	input  wire logic               i_reset_n,
	// Divider input and setup
	input  wire logic               i_level,
	input  var  dpll_pkg::div_cfg_t i_cfg,
	// Divided event
	output logic                    o_event
);

	dpll_pkg::div_state_t q;
	dpll_pkg::div_state_t d;
	logic                 edge_hit;

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		d = q;
		d.ev = 1'b0;
		d.prev = i_level;
		edge_hit = i_cfg.fall ? (q.prev & ~i_level) : (~q.prev & i_level);
		if (edge_hit) begin
			if (q.cnt == dpll_pkg::DIV_W'(i_cfg.modulus - 16'h1)) begin
				d.cnt = '0;
				if (i_cfg.div2) begin
					d.half = ~q.half;
					d.ev = q.half;
				end else begin
					d.ev = 1'b1;
				end
			end else begin
				d.cnt = dpll_pkg::DIV_W'(q.cnt + 16'h1);
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign o_event = q.ev;

endmodule : dpll_divider
`default_nettype wire

// *** rtl/dpll_core.sv ***
// Digital loop core: reference selection, dividers, phase detector,
// frequency estimator, loop filter, holdover and phase accumulator.
// Assumes reference and feedback pins are asynchronous to the system clock.
`timescale 1ns/10ps
`default_nettype none

module dpll_core #(
	parameter int LOSS_CYCLES = dpll_pkg::LOSS_CYCLES
) (
	// Clock and reset
	input  wire logic                         i_sys_clk,
	input  wire logic                         i_reset_n,
	// Reference and feedback pins
	input  wire logic                         i_ref_a,
	input  wire logic                         i_ref_b,
	input  wire logic                         i_feedback_clock_input,
	// Divider setup
	input  var  dpll_pkg::div_cfg_t           i_ref_div_cfg,
	input  var  dpll_pkg::div_cfg_t           i_fb_div_cfg,
	// Loop control
	input  wire logic                         i_close_loop,
	input  wire logic                         i_freq_est_en,
	input  wire logic                         i_auto_switch,
	input  wire logic                         i_manual_ref_sel,
	input  wire logic                         i_auto_holdover,
	input  wire logic                         i_manual_holdover,
	input  wire logic [dpll_pkg::SH_W-1:0]    i_prop_shift,
	input  wire logic [dpll_pkg::SH_W-1:0]    i_int_shift,
	input  wire logic [dpll_pkg::FTW_W-1:0]   i_single_tone_ftw,
	// Synthesizer outputs
	output logic [dpll_pkg::FTW_W-1:0]        o_frequency_tuning_word,
	output logic [dpll_pkg::FTW_W-1:0]        o_phase_accumulator,
	output logic                              o_synth_clock,
	// Detector outputs
	output logic [dpll_pkg::PE_W-1:0]         o_phase_error,
	output logic                              o_phase_error_valid,
	output logic                              o_fine_selected,
	// Status
	output logic                              o_active_ref,
	output logic [1:0]                        o_ref_lost,
	output logic                              o_holdover,
	output logic                              o_history_valid,
	output dpll_pkg::loop_state_t             o_loop_state
);

	dpll_pkg::core_state_t            q;
	dpll_pkg::core_state_t            d;
	logic                             ref_ev;
	logic                             fb_ev;
	logic                             ref_level;
	logic [dpll_pkg::NPIN-1:0]        pins;
	logic                             hold_req;
	logic                             pfd_clear;
	logic                             up_n;
	logic                             dn_n;
	logic                             fine_ovf;
	logic [dpll_pkg::DIV_W+1:0]       s_eff;
	logic [dpll_pkg::PE_W:0]          rem_sh;
	logic signed [dpll_pkg::FTW_W-1:0] err_ext;
	logic signed [dpll_pkg::FTW_W-1:0] integ_n;
	logic signed [dpll_pkg::FTW_W-1:0] avg_diff;

	assign pins = {i_feedback_clock_input, i_ref_b, i_ref_a};

	// ************************************************************
	// Dividers
	// ************************************************************
	assign ref_level = q.lvl[q.active];

	dpll_divider u_ref_div (
		.i_sys_clk (i_sys_clk),
		.i_reset_n (i_reset_n),
		.i_level   (ref_level),
		.i_cfg     (i_ref_div_cfg),
		.o_event   (ref_ev)
	);

	dpll_divider u_fb_div (
		.i_sys_clk (i_sys_clk),
		.i_reset_n (i_reset_n),
		.i_level   (q.lvl[dpll_pkg::PIN_FB]),
		.i_cfg     (i_fb_div_cfg),
		.o_event   (fb_ev)
	);

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		d = q;
		d.err_vld = 1'b0;
		pfd_clear = 1'b0;
		fine_ovf = 1'b0;
		rem_sh = '0;
		err_ext = '0;
		integ_n = '0;
		avg_diff = '0;
		s_eff = {2'h0, i_fb_div_cfg.modulus} << i_fb_div_cfg.div2;

		// Pin synchronisers: a change counts once stages two and three agree
		for (int i = 0; i < dpll_pkg::NPIN; i++) begin
			d.sync[i] = {q.sync[i][1:0], pins[i]};
			if (q.sync[i][1] == q.sync[i][2]) begin
				d.lvl[i] = q.sync[i][2];
			end
		end

		// Reference loss monitors
		for (int i = 0; i < 2; i++) begin
			if (d.lvl[i] != q.lvl[i]) begin
				d.loss_cnt[i] = '0;
				d.lost[i] = 1'b0;
			end else if (q.loss_cnt[i] == dpll_pkg::LOSS_W'(LOSS_CYCLES - 1)) begin
				d.lost[i] = 1'b1;
			end else begin
				d.loss_cnt[i] = dpll_pkg::LOSS_W'(q.loss_cnt[i] + 24'h1);
			end
		end

		// Reference switchover
		if (i_auto_switch) begin
			if (q.lost[q.active] && !q.lost[~q.active]) begin
				d.active = ~q.active;
			end
		end else begin
			d.active = i_manual_ref_sel;
		end
		if (d.active != q.active) begin
			pfd_clear = 1'b1;
		end

		// Three-state detector with coarse and fine width counters
		up_n = q.up | ref_ev;
		dn_n = q.dn | fb_ev;
		if (pfd_clear) begin
			d.up = 1'b0;
			d.dn = 1'b0;
			d.coarse = '0;
			d.fine = '0;
		end else if (up_n && dn_n) begin
			fine_ovf = &q.fine;
			d.fine_sel = ~fine_ovf;
			if (!fine_ovf) begin
				d.err = dpll_pkg::PE_W'(q.fine);
			end else begin
				d.err = q.coarse;
			end
			if (q.dn) begin
				d.err = dpll_pkg::PE_W'(24'h0 - d.err);
			end
			d.err_vld = 1'b1;
			d.up = 1'b0;
			d.dn = 1'b0;
			d.coarse = '0;
			d.fine = '0;
		end else begin
			d.up = up_n;
			d.dn = dn_n;
			if (up_n || dn_n) begin
				if (!(&q.coarse)) begin
					d.coarse = dpll_pkg::PE_W'(q.coarse + 24'h1);
				end
				if (!(&q.fine)) begin
					d.fine = dpll_pkg::FINE_W'(q.fine + 10'h1);
				end
			end
		end

		// Holdover request
		hold_req = i_manual_holdover
			| (i_auto_holdover & q.lost[q.active] & (q.lost[~q.active] | ~i_auto_switch));

		// Loop sequencing
		err_ext = dpll_pkg::FTW_W'($signed(q.err));
		case (q.st)
			dpll_pkg::ST_OPEN: begin
				d.frequency_tuning_word = i_single_tone_ftw;
				d.integ = i_single_tone_ftw;
				if (i_close_loop) begin
					d.started = 1'b0;
					d.per_cnt = '0;
					d.st = i_freq_est_en ? dpll_pkg::ST_MEAS : dpll_pkg::ST_TRACK;
				end
			end
			dpll_pkg::ST_MEAS: begin
				if (!(&q.per_cnt)) begin
					d.per_cnt = dpll_pkg::PE_W'(q.per_cnt + 24'h1);
				end
				if (ref_ev) begin
					d.started = 1'b1;
					d.per_cnt = '0;
					if (q.started) begin
						d.period = q.per_cnt + 24'h1;
						d.rem = dpll_pkg::PE_W'(s_eff) + 25'h0;
						d.quo = '0;
						d.bits = dpll_pkg::DIV_STEPS;
						d.st = dpll_pkg::ST_DIVIDE;
					end
				end
			end
			dpll_pkg::ST_DIVIDE: begin
				if ({7'h0, s_eff} >= {1'b0, q.period}) begin
					d.integ = dpll_pkg::FTW_MAX;
					d.frequency_tuning_word = dpll_pkg::FTW_MAX;
					d.st = dpll_pkg::ST_TRACK;
				end else begin
					rem_sh = {q.rem[dpll_pkg::PE_W-1:0], 1'b0};
					d.quo = {q.quo[dpll_pkg::FTW_W-2:0], 1'b0};
					if (rem_sh >= {1'b0, q.period}) begin
						rem_sh = rem_sh - {1'b0, q.period};
						d.quo[0] = 1'b1;
					end
					d.rem = rem_sh;
					d.bits = dpll_pkg::BIT_W'(q.bits - 6'h1);
					if (q.bits == '0) begin
						d.integ = d.quo;
						d.frequency_tuning_word = d.quo;
						d.avg = d.quo;
						d.st = dpll_pkg::ST_TRACK;
					end
				end
			end
			dpll_pkg::ST_TRACK: begin
				if (q.err_vld) begin
					integ_n = $signed(q.integ) + (err_ext <<< i_int_shift);
					d.integ = integ_n;
					d.frequency_tuning_word = dpll_pkg::FTW_W'(integ_n + (err_ext <<< i_prop_shift));
					avg_diff = $signed(q.frequency_tuning_word) - $signed(q.avg);
					d.avg = dpll_pkg::FTW_W'($signed(q.avg) + (avg_diff >>> dpll_pkg::AVG_SHIFT));
					if (!q.hist) begin
						d.avg = q.frequency_tuning_word;
					end
					d.hist = 1'b1;
				end
				if (hold_req && q.hist) begin
					d.st = dpll_pkg::ST_HOLD;
				end
			end
			dpll_pkg::ST_HOLD: begin
				d.frequency_tuning_word = q.avg;
				if (!hold_req) begin
					d.integ = q.avg;
					d.st = dpll_pkg::ST_TRACK;
				end
			end
			default: begin
				d.st = dpll_pkg::ST_OPEN;
			end
		endcase
		if (!i_close_loop) begin
			d.st = dpll_pkg::ST_OPEN;
		end

		// Phase accumulator wraps modulo 2^48 and keeps the excess
		d.acc = dpll_pkg::FTW_W'(q.acc + q.frequency_tuning_word);
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign o_frequency_tuning_word = q.frequency_tuning_word;
	assign o_phase_accumulator     = q.acc;
	assign o_synth_clock           = q.acc[dpll_pkg::FTW_W-1];
	assign o_phase_error           = q.err;
	assign o_phase_error_valid     = q.err_vld;
	assign o_fine_selected         = q.fine_sel;
	assign o_active_ref            = q.active;
	assign o_ref_lost              = q.lost;
	assign o_holdover              = (q.st == dpll_pkg::ST_HOLD);
	assign o_history_valid         = q.hist;
	assign o_loop_state            = q.st;

endmodule : dpll_core
`default_nettype wire

// *** bench/dpll_ref_source.sv ***
// Reference pair and feedback clock sources facing the loop core.
// Assumes 1 ns units; a stopped source holds its level.
`timescale 1ns/10ps
`default_nettype none

module dpll_ref_source #(
	parameter int HALF_A  = 100,
	parameter int HALF_B  = 110,
	parameter int HALF_FB = 33
) (
	// Run controls
	input  wire logic i_run_a,
	input  wire logic i_run_b,
	// Pins toward the core
	output var  logic o_ref_a,
	output var  logic o_ref_b,
	output var  logic o_fb
);
	// ************
	// Source clocks
	// ************
	initial begin
		o_ref_a = 1'b0;
		o_ref_b = 1'b0;
		o_fb = 1'b0;
	end
	always #(HALF_A) if (i_run_a) o_ref_a = ~o_ref_a;
	always #(HALF_B) if (i_run_b) o_ref_b = ~o_ref_b;
	always #(HALF_FB) o_fb = ~o_fb;
endmodule : dpll_ref_source

`default_nettype wire

// *** bench/dpll_core_monitor.sv ***
// Concurrent checks on the loop core ports.
// Assumes it is bound into the core and sees its ports only.
`timescale 1ns/10ps
`default_nettype none

module dpll_core_monitor #(
	parameter int LOSS_CYCLES = 50
) (
	// Clock and reset
	input wire logic                       i_sys_clk,
	input wire logic                       i_reset_n,
	// Controls
	input wire logic                       i_ref_a,
	input wire logic                       i_close_loop,
	input wire logic                       i_auto_switch,
	input wire logic                       i_manual_ref_sel,
	// Outputs
	input wire logic [dpll_pkg::FTW_W-1:0] o_frequency_tuning_word,
	input wire logic [dpll_pkg::FTW_W-1:0] o_phase_accumulator,
	input wire logic [dpll_pkg::PE_W-1:0]  o_phase_error,
	input wire logic                       o_phase_error_valid,
	input wire logic                       o_active_ref,
	input wire logic [1:0]                 o_ref_lost,
	input wire logic                       o_holdover,
	input wire logic                       o_history_valid,
	input var  dpll_pkg::loop_state_t      o_loop_state
);
	// ************
	// Properties
	// ************
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_reset_n);

	// Cycles since reference A last changed at its pin
	logic ref_a_q;
	int   same_a_q;

	always_ff @(posedge i_sys_clk) begin
		ref_a_q <= i_ref_a;
		if (i_ref_a != ref_a_q) begin
			same_a_q <= 0;
		end else if (same_a_q < LOSS_CYCLES) begin
			same_a_q <= same_a_q + 1;
		end
	end

	chk_loss_time: assert property ($rose(o_ref_lost[0]) |-> same_a_q >= LOSS_CYCLES)
		else $error("early loss");
	chk_acc_adds: assert property ($past(i_reset_n) |-> o_phase_accumulator ==
		$past(o_phase_accumulator) + $past(o_frequency_tuning_word)) else $error("acc step");
	chk_open_state: assert property ($past(i_reset_n) && !$past(i_close_loop) |->
		o_loop_state == dpll_pkg::ST_OPEN) else $error("not open");
	chk_valid_pulse: assert property (o_phase_error_valid |=> !o_phase_error_valid)
		else $error("valid long");
	chk_err_hold: assert property (!o_phase_error_valid |-> $stable(o_phase_error))
		else $error("error moved");
	chk_hold_flag: assert property (o_holdover |-> o_history_valid && $past(i_close_loop))
		else $error("hold flag");
	chk_hold_entry: assert property ($rose(o_holdover) |-> o_history_valid &&
		$past(o_loop_state) == dpll_pkg::ST_TRACK) else $error("hold entry");
	chk_hold_steady: assert property (o_holdover [*3] |->
		$stable(o_frequency_tuning_word)) else $error("hold word moved");
	chk_auto_move: assert property (i_auto_switch && !o_active_ref && o_ref_lost == 2'b01
		|-> ##[1:4] o_active_ref) else $error("no switch");
	chk_manual_sel: assert property ((!i_auto_switch && i_manual_ref_sel) [*3] |->
		o_active_ref) else $error("manual select");
endmodule : dpll_core_monitor

bind dpll_core dpll_core_monitor #(.LOSS_CYCLES(LOSS_CYCLES)) u_dpll_core_monitor (
	.i_sys_clk, .i_reset_n, .i_ref_a, .i_close_loop, .i_auto_switch, .i_manual_ref_sel,
	.o_frequency_tuning_word, .o_phase_accumulator, .o_phase_error, .o_phase_error_valid,
	.o_active_ref, .o_ref_lost, .o_holdover, .o_history_valid, .o_loop_state);

`default_nettype wire

// *** bench/tb_dpll_core.sv ***
// Self-checking bench for the loop core with its reference sources.
// Assumes package, core, source model and monitor are compiled first.
`timescale 1ns/10ps
`default_nettype none

module tb_dpll_core;
	// ************
	// Signals
	// ************
	localparam int LOSS = 50;
	logic               i_sys_clk, i_reset_n, i_close_loop, i_freq_est_en, i_auto_switch;
	logic               i_manual_ref_sel, i_auto_holdover, i_manual_holdover, run_a;
	logic [3:0]         i_prop_shift, i_int_shift;
	logic [47:0]        i_single_tone_ftw, o_frequency_tuning_word, o_phase_accumulator;
	logic [23:0]        o_phase_error;
	logic [1:0]         o_ref_lost;
	logic               o_synth_clock, o_phase_error_valid, o_fine_selected;
	logic               o_active_ref, o_holdover, o_history_valid;
	wire logic          i_ref_a, i_ref_b, i_feedback_clock_input;
	dpll_pkg::div_cfg_t i_ref_div_cfg, i_fb_div_cfg;
	dpll_pkg::loop_state_t o_loop_state;
	logic [31:0]        seed;
	logic [47:0]        a0, integ, err, avg, ftw_exp;
	int                 miscompares, total_checks, cycles, n;

	dpll_core #(.LOSS_CYCLES(LOSS)) u_dpll_core (.i_sys_clk, .i_reset_n, .i_ref_a, .i_ref_b,
		.i_feedback_clock_input, .i_ref_div_cfg, .i_fb_div_cfg, .i_close_loop, .i_freq_est_en,
		.i_auto_switch, .i_manual_ref_sel, .i_auto_holdover, .i_manual_holdover,
		.i_prop_shift, .i_int_shift, .i_single_tone_ftw, .o_frequency_tuning_word,
		.o_phase_accumulator, .o_synth_clock, .o_phase_error, .o_phase_error_valid,
		.o_fine_selected, .o_active_ref, .o_ref_lost, .o_holdover, .o_history_valid,
		.o_loop_state);
	dpll_ref_source u_dpll_ref_source (.i_run_a(run_a), .i_run_b(1'b1), .o_ref_a(i_ref_a),
		.o_ref_b(i_ref_b), .o_fb(i_feedback_clock_input));

	// ************
	// Helpers
	// ************
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	function automatic logic [47:0] est_ftw(input int s_eff, input int period);
		logic [63:0] num;
		num = 64'(s_eff) << 48;
		return 48'(num / 64'(period));
	endfunction : est_ftw

	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic cyc(input int k);
		repeat (k) @(negedge i_sys_clk);
	endtask : cyc

	task automatic wait_state(input dpll_pkg::loop_state_t s);
		n = 0;
		while (o_loop_state !== s && n < 400) begin
			cyc(1);
			n++;
		end
		check(o_loop_state, s);
	endtask : wait_state

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : tally_and_finish

	// ************
	// Clock and watchdog
	// ************
	initial i_sys_clk = 1'b0;
	always #(dpll_pkg::CLK_PERIOD_NS / 2) i_sys_clk = ~i_sys_clk;
	always @(posedge i_sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			tally_and_finish();
		end
	end

	// ************
	// Scenarios
	// ************
	initial begin
		seed = 32'h1A5FFA3D;
		{i_reset_n, i_close_loop, i_auto_switch, i_manual_ref_sel} = 4'h0;
		{i_auto_holdover, i_manual_holdover, i_prop_shift, i_int_shift} = 10'h000;
		{i_freq_est_en, run_a, i_single_tone_ftw} = {2'h3, 48'h0};
		i_ref_div_cfg = '{modulus: 16'h0002, div2: 1'b0, fall: 1'b1};
		i_fb_div_cfg = '{modulus: 16'h0003, div2: 1'b1, fall: 1'b0};
		cyc(3);
		i_reset_n = 1'b1;
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			i_single_tone_ftw = (i == 0) ? 48'hFFFFFFFFFFFF : {seed[15:0], seed};
			cyc(3);
			a0 = o_phase_accumulator;
			cyc(1);
			check(o_loop_state, dpll_pkg::ST_OPEN);
			check(o_frequency_tuning_word, i_single_tone_ftw);
			check(o_phase_accumulator - a0, i_single_tone_ftw);
			check(o_synth_clock, o_phase_accumulator[47]);
		end
		seed = lfsr(seed);
		i_prop_shift = {2'h0, seed[1:0]};
		i_int_shift = {2'h0, seed[3:2]};
		i_close_loop = 1'b1;
		wait_state(dpll_pkg::ST_MEAS);
		wait_state(dpll_pkg::ST_TRACK);
		integ = est_ftw(6, 20);
		ftw_exp = integ;
		check(o_frequency_tuning_word, integ);
		for (int i = 0; i < 6; i++) begin
			n = 0;
			while (o_phase_error_valid !== 1'b1 && n < 100) begin
				cyc(1);
				n++;
			end
			err = {{24{o_phase_error[23]}}, o_phase_error};
			check(o_phase_error_valid, 1'b1);
			check(o_fine_selected,
				(o_phase_error[23] ? -o_phase_error : o_phase_error) < 24'd1023);
			if (i == 0) begin
				avg = ftw_exp;
			end else begin
				avg = avg + 48'($signed(ftw_exp - avg) >>> dpll_pkg::AVG_SHIFT);
			end
			integ = integ + (err << i_int_shift);
			ftw_exp = integ + (err << i_prop_shift);
			cyc(1);
			check(o_frequency_tuning_word, ftw_exp);
		end
		check(o_history_valid, 1'b1);
		i_manual_holdover = 1'b1;
		wait_state(dpll_pkg::ST_HOLD);
		cyc(1);
		check(o_frequency_tuning_word, avg);
		a0 = o_phase_accumulator;
		cyc(1);
		check(o_phase_accumulator - a0, avg);
		i_manual_holdover = 1'b0;
		wait_state(dpll_pkg::ST_TRACK);
		i_auto_switch = 1'b1;
		run_a = 1'b0;
		cyc(LOSS + 20);
		check(o_ref_lost, 2'b01);
		check(o_active_ref, 1'b1);
		run_a = 1'b1;
		cyc(30);
		check(o_ref_lost, 2'b00);
		i_auto_switch = 1'b0;
		for (int i = 0; i < 2; i++) begin
			i_manual_ref_sel = ~i_manual_ref_sel;
			cyc(5);
			check(o_active_ref, i_manual_ref_sel);
		end
		i_close_loop = 1'b0;
		cyc(2);
		check(o_loop_state, dpll_pkg::ST_OPEN);
		i_freq_est_en = 1'b0;
		i_close_loop = 1'b1;
		cyc(1);
		check(o_loop_state, dpll_pkg::ST_TRACK);
		check(o_frequency_tuning_word, i_single_tone_ftw);
		i_auto_holdover = 1'b1;
		run_a = 1'b0;
		wait_state(dpll_pkg::ST_HOLD);
		check(o_ref_lost, 2'b01);
		tally_and_finish();
	end
endmodule : tb_dpll_core

`default_nettype wire
